// File: inc/spavg_pkg.sv
// Functional notes
// - Power mode squares real and imaginary, adds, accumulates per bin each transform.
// - K is a power of two from 4 to 256 for all modes.
// - After K power transforms each bin sum is divided by K.
// - Each of 256 bins averages independently of all others.
// - Power result is square-rooted before display, giving amplitude.
// - Power mode averages per-transform phase atan(im/re) arithmetically over K.
// - Interim averages shown while running; display off skips interim root work.
// - Larger K after completion continues from existing sums instead of restarting.
// - Exponential mode: new average is latest/4 plus previous times 3/4.
// - Time mode sums K triggered records sample by sample, divides by K.
// - Each time record starts at the trigger point.
// - Time mode offers both averaged record and its transform.
// - Time mode requests a single FFT on the averaged record.
// - Internal trigger comes only from channel A, with slope and level.
// - External trigger is a logic level; any channel mix may be averaged.
// - Exponential request while in time mode is refused with an error flag.
// - Peak mode keeps the larger of new and stored value per bin.
// - Unbounded-run key in peak mode runs maxima forever until stopped.
package spavg_pkg;
  localparam int DATA_W = 16;
  localparam int NBINS = 256;
  localparam int BIN_W = 8;
  localparam int KLOG_W = 4;
  localparam logic [3:0] KLOG_MIN = 4'h2;
  localparam logic [3:0] KLOG_MAX = 4'h8;
  localparam logic [3:0] KLOG_RST = 4'h2;
  localparam int ACC_W = 2 * DATA_W + 1 + 8;
  localparam int PH_W = 16;
  localparam int PHACC_W = PH_W + 8;
  localparam logic [31:0] ADDR_CTRL = 32'h00000000;
  localparam logic [31:0] ADDR_TRIG = 32'h00000004;
  localparam logic [31:0] ADDR_STAT = 32'h00000008;
  localparam logic [31:0] ADDR_RADDR = 32'h0000000C;
  localparam logic [31:0] ADDR_RDATA = 32'h00000010;
  localparam logic [31:0] ADDR_RPHASE = 32'h00000014;
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_MODE = 2;
  localparam int CTRL_KLOG = 4;
  localparam int CTRL_UNB = 8;
  localparam int CTRL_DISP = 9;
  localparam int CTRL_EXTTRIG = 10;
  localparam int CTRL_CHMASK = 11;
  localparam int CTRL_EXPREQ = 13;
  localparam int TRIG_SLOPE = 16;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ERR = 2;
  localparam int STAT_CNT = 8;
  localparam logic [1:0] MODE_POWER = 2'h0;
  localparam logic [1:0] MODE_EXP = 2'h1;
  localparam logic [1:0] MODE_TIME = 2'h2;
  localparam logic [1:0] MODE_PEAK = 2'h3;
  typedef enum logic [1:0] {SPAVG_IDLE, SPAVG_RUN, SPAVG_SQRT, SPAVG_FFT} spavg_state_type;
endpackage : spavg_pkg

// File: rtl/spavg_engine.sv
module spavg_engine #(
  parameter int NBIN = spavg_pkg::NBINS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_fft_valid,
  input wire logic [spavg_pkg::BIN_W-1:0] i_fft_bin,
  input wire logic signed [spavg_pkg::DATA_W-1:0] i_fft_re,
  input wire logic signed [spavg_pkg::DATA_W-1:0] i_fft_im,
  input wire logic signed [spavg_pkg::PH_W-1:0] i_fft_phase,
  input wire logic i_smp_valid,
  input wire logic [spavg_pkg::BIN_W-1:0] i_smp_idx,
  input wire logic signed [spavg_pkg::DATA_W-1:0] i_smp_a,
  input wire logic signed [spavg_pkg::DATA_W-1:0] i_smp_b,
  input wire logic i_ext_trig,
  output logic o_trig,
  output logic o_fft_req,
  output logic [spavg_pkg::BIN_W-1:0] o_tavg_idx,
  output logic signed [spavg_pkg::DATA_W-1:0] o_tavg_data,
  output logic o_tavg_valid,
  output logic o_done
);
  import spavg_pkg::*;

  initial begin
    if (NBIN != NBINS) $error("spavg_engine: NBIN must equal 256");
  end

  // Per-bin stores; one slot per bin keeps bins independent
  logic [ACC_W-1:0] acc_mem [0:NBINS-1];
  logic signed [PHACC_W-1:0] ph_mem [0:NBINS-1];
  logic [DATA_W-1:0] amp_mem [0:NBINS-1];

  logic [1:0] mode;
  logic [3:0] klog;
  logic unbounded;
  logic disp_on;
  logic ext_sel;
  logic [1:0] ch_mask;
  logic trig_slope;
  logic signed [DATA_W-1:0] trig_level;
  logic err_flag;
  logic [8:0] rec_cnt;
  logic [BIN_W-1:0] rd_addr;
  spavg_state_type state;
  logic [BIN_W-1:0] clr_idx;
  logic clr_busy;
  logic [BIN_W-1:0] sq_idx;
  logic sq_final;
  logic rec_arm;
  logic rec_open;
  logic prev_above;
  logic prev_ext;
  logic [DATA_W-1:0] isq_root;
  logic [ACC_W-1:0] isq_val;

  wire apb_wr = i_psel && i_penable && i_pwrite;
  wire apb_rd = i_psel && !i_penable && !i_pwrite;
  wire ctrl_wr = apb_wr && i_paddr == ADDR_CTRL;
  wire start_cmd = ctrl_wr && i_pwdata[CTRL_START];
  wire stop_cmd = ctrl_wr && i_pwdata[CTRL_STOP];
  wire [3:0] w_klog = i_pwdata[CTRL_KLOG +: 4];
  // Only power-of-two K from 4 to 256 accepted
  wire klog_ok = w_klog >= KLOG_MIN && w_klog <= KLOG_MAX;
  wire [8:0] k_val = 9'h001 << klog;
  wire running = state == SPAVG_RUN && !clr_busy;
  wire limit_hit = !(mode == MODE_PEAK && unbounded) && rec_cnt >= k_val;

  // Squared magnitude of the incoming bin, sized to avoid overflow
  wire [2*DATA_W-1:0] sq_re = (2*DATA_W)'($signed(i_fft_re) * $signed(i_fft_re));
  wire [2*DATA_W-1:0] sq_im = (2*DATA_W)'($signed(i_fft_im) * $signed(i_fft_im));
  wire [ACC_W-1:0] pwr = ACC_W'(sq_re) + ACC_W'(sq_im);

  // Integer square root of a right-shifted sum, restoring compare-and-subtract form
  function automatic logic [DATA_W-1:0] isqrt(input logic [ACC_W-1:0] v);
    logic [ACC_W-1:0] rem;
    logic [DATA_W-1:0] root;
    logic [ACC_W-1:0] trial;
    rem = v;
    root = '0;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      trial = ACC_W'((ACC_W'(root) << (i + 1)) + (ACC_W'(1) << (2 * i)));
      if (rem >= trial) begin
        rem = rem - trial;
        root = root | DATA_W'(1 << i);
      end
    end
    return root;
  endfunction : isqrt

  // Sum divided by K via shift by log2 K
  always_comb begin
    isq_val = acc_mem[sq_idx] >> klog;
    isq_root = isqrt(isq_val);
  end

  // Trigger: internal from channel A only with slope and level, or external rising edge
  wire a_above = i_smp_a >= trig_level;
  wire int_edge = i_smp_valid && i_smp_idx == '0 &&
                  (trig_slope ? (!a_above && prev_above) : (a_above && !prev_above));
  wire ext_edge = i_ext_trig && !prev_ext;
  wire trig_ev = ext_sel ? ext_edge : int_edge;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_above <= 1'b0;
      prev_ext <= 1'b0;
      o_trig <= 1'b0;
    end else begin
      if (i_smp_valid && i_smp_idx == '0) prev_above <= a_above;
      prev_ext <= i_ext_trig;
      o_trig <= trig_ev;
    end
  end

  // Configuration registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode <= MODE_POWER;
      klog <= KLOG_RST;
      unbounded <= 1'b0;
      disp_on <= 1'b1;
      ext_sel <= 1'b0;
      ch_mask <= 2'h2;
      trig_slope <= 1'b0;
      trig_level <= '0;
      rd_addr <= '0;
    end else if (apb_wr) begin
      if (i_paddr == ADDR_CTRL) begin
        // Exponential request in time mode is refused
        if (!(i_pwdata[CTRL_EXPREQ] && mode == MODE_TIME)) begin
          mode <= i_pwdata[CTRL_MODE +: 2];
        end
        if (klog_ok) klog <= w_klog;
        unbounded <= i_pwdata[CTRL_UNB];
        disp_on <= i_pwdata[CTRL_DISP];
        ext_sel <= i_pwdata[CTRL_EXTTRIG];
        // Internal trigger allows channel B only; external allows any mix
        ch_mask <= i_pwdata[CTRL_EXTTRIG] ? i_pwdata[CTRL_CHMASK +: 2] : 2'h2;
      end
      if (i_paddr == ADDR_TRIG) begin
        trig_level <= i_pwdata[DATA_W-1:0];
        trig_slope <= i_pwdata[TRIG_SLOPE];
      end
      if (i_paddr == ADDR_RADDR) rd_addr <= i_pwdata[BIN_W-1:0];
    end
  end

  // Error flag: set wins over a clear in the same write
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      err_flag <= 1'b0;
    end else if (ctrl_wr && i_pwdata[CTRL_EXPREQ] && mode == MODE_TIME) begin
      err_flag <= 1'b1;
    end else if (apb_wr && i_paddr == ADDR_STAT && i_pwdata[STAT_ERR]) begin
      err_flag <= 1'b0;
    end
  end

  // Run control, clear sweep, record count and done
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= SPAVG_IDLE;
      clr_busy <= 1'b0;
      clr_idx <= '0;
      rec_cnt <= '0;
      o_done <= 1'b0;
      sq_idx <= '0;
      sq_final <= 1'b0;
      o_fft_req <= 1'b0;
      rec_arm <= 1'b0;
      rec_open <= 1'b0;
    end else begin
      o_fft_req <= 1'b0;
      // Request and done follow the last streamed sample, not its launch
      if (o_tavg_valid && o_tavg_idx == 8'hFF) begin
        o_fft_req <= 1'b1;
        o_done <= 1'b1;
      end
      if (stop_cmd) begin
        state <= SPAVG_IDLE;
        rec_arm <= 1'b0;
        rec_open <= 1'b0;
      end else if (start_cmd) begin
        state <= SPAVG_RUN;
        clr_busy <= 1'b1;
        clr_idx <= '0;
        rec_cnt <= '0;
        o_done <= 1'b0;
        rec_arm <= 1'b1;
        rec_open <= 1'b0;
      end else begin
        case (state)
          SPAVG_IDLE: begin
            // Larger K after done resumes from the existing sums
            if (o_done && ctrl_wr && klog_ok && (9'h001 << w_klog) > rec_cnt &&
                (mode == MODE_POWER || mode == MODE_TIME || mode == MODE_PEAK)) begin
              state <= SPAVG_RUN;
              o_done <= 1'b0;
              rec_arm <= 1'b1;
            end
          end
          SPAVG_RUN: begin
            if (clr_busy) begin
              clr_idx <= clr_idx + 8'h01;
              if (clr_idx == 8'hFF) clr_busy <= 1'b0;
            end else if (mode == MODE_TIME) begin
              // Record opens only at the trigger point
              if (rec_arm && trig_ev) begin
                rec_open <= 1'b1;
                rec_arm <= 1'b0;
              end
              if (rec_open && i_smp_valid && i_smp_idx == 8'hFF) begin
                rec_open <= 1'b0;
                rec_cnt <= rec_cnt + 9'h001;
                if (rec_cnt + 9'h001 >= k_val) begin
                  state <= SPAVG_FFT;
                  sq_idx <= '0;
                end else begin
                  rec_arm <= 1'b1;
                end
              end
            end else if (i_fft_valid && i_fft_bin == 8'hFF) begin
              rec_cnt <= rec_cnt + 9'h001;
              // Interim roots only when display on; final pass always
              if (mode == MODE_POWER && (disp_on || rec_cnt + 9'h001 >= k_val)) begin
                state <= SPAVG_SQRT;
                sq_idx <= '0;
                sq_final <= rec_cnt + 9'h001 >= k_val;
              end else if (mode != MODE_EXP && !(mode == MODE_PEAK && unbounded) &&
                           rec_cnt + 9'h001 >= k_val) begin
                state <= SPAVG_IDLE;
                o_done <= 1'b1;
              end
            end
          end
          SPAVG_SQRT: begin
            sq_idx <= sq_idx + 8'h01;
            if (sq_idx == 8'hFF) begin
              state <= sq_final ? SPAVG_IDLE : SPAVG_RUN;
              o_done <= sq_final;
            end
          end
          SPAVG_FFT: begin
            // Stream averaged record out, then one FFT request
            sq_idx <= sq_idx + 8'h01;
            if (sq_idx == 8'hFF) begin
              state <= SPAVG_IDLE;
            end
          end
          default: state <= SPAVG_IDLE;
        endcase
      end
    end
  end

  // Time-average output stream, sum shifted by log2 K
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tavg_valid <= 1'b0;
      o_tavg_idx <= '0;
      o_tavg_data <= '0;
    end else begin
      o_tavg_valid <= state == SPAVG_FFT;
      o_tavg_idx <= sq_idx;
      o_tavg_data <= DATA_W'($signed(acc_mem[sq_idx]) >>> klog);
    end
  end

  // Per-bin accumulator update; memories carry no reset
  always_ff @(posedge i_clk) begin
    if (clr_busy && state == SPAVG_RUN) begin
      acc_mem[clr_idx] <= '0;
      ph_mem[clr_idx] <= '0;
      amp_mem[clr_idx] <= '0;
    end else if (running && !limit_hit) begin
      if (mode == MODE_TIME) begin
        if (rec_open && i_smp_valid) begin
          // Sum selected channels sample by sample
          acc_mem[i_smp_idx] <= acc_mem[i_smp_idx]
            + (ch_mask[0] ? ACC_W'(i_smp_a) : '0)
            + (ch_mask[1] ? ACC_W'(i_smp_b) : '0);
        end
      end else if (i_fft_valid) begin
        case (mode)
          MODE_POWER: begin
            acc_mem[i_fft_bin] <= acc_mem[i_fft_bin] + pwr;
            ph_mem[i_fft_bin] <= ph_mem[i_fft_bin] + PHACC_W'(i_fft_phase);
          end
          MODE_EXP: begin
            // New = latest/4 + 3/4 previous
            acc_mem[i_fft_bin] <= (pwr >> 2) + (acc_mem[i_fft_bin] >> 2)
              + (acc_mem[i_fft_bin] >> 1);
          end
          MODE_PEAK: begin
            // Keep the larger per bin
            if (pwr > acc_mem[i_fft_bin]) acc_mem[i_fft_bin] <= pwr;
          end
          default: acc_mem[i_fft_bin] <= acc_mem[i_fft_bin];
        endcase
      end
    end
    if (state == SPAVG_SQRT) begin
      amp_mem[sq_idx] <= isq_root;
    end
  end

  // APB slave: zero wait state, unmapped reads zero with error
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= '0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      if (i_psel && !i_penable && i_paddr > ADDR_RPHASE) o_pslverr <= 1'b1;
      if (apb_rd) begin
        case (i_paddr)
          ADDR_CTRL: o_prdata <= {19'h0, ch_mask, ext_sel, disp_on, unbounded,
                                  klog, mode, 2'h0};
          ADDR_TRIG: o_prdata <= {15'h0, trig_slope, trig_level};
          ADDR_STAT: o_prdata <= {15'h0, rec_cnt, 5'h0, err_flag, o_done,
                                  state != SPAVG_IDLE};
          ADDR_RADDR: o_prdata <= {24'h0, rd_addr};
          ADDR_RDATA: o_prdata <= (mode == MODE_POWER) ? {16'h0, amp_mem[rd_addr]}
                                                       : acc_mem[rd_addr][31:0];
          // Arithmetic mean of phases, shift by log2 K
          ADDR_RPHASE: o_prdata <= 32'($signed(ph_mem[rd_addr]) >>> klog);
          default: o_prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule : spavg_engine

// File: bench/spavg_engine_sva.sv
module spavg_engine_chk #(
  parameter int NBIN = 256
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_fft_req,
  input wire logic [spavg_pkg::BIN_W-1:0] o_tavg_idx,
  input wire logic o_tavg_valid,
  input wire logic o_done
);
  timeunit 1ns;
  timeprecision 1ns;
  import spavg_pkg::*;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // Bus qualifiers; a start is only real at the access edge
  wire setup = i_psel && !i_penable;
  wire start = i_psel && i_penable && i_pwrite && (i_paddr == ADDR_CTRL)
    && i_pwdata[CTRL_START];
  AST_PREADY_ANSWER: assert property (setup |=> o_pready && i_penable)
    else $error("no ready one cycle after setup");
  AST_PREADY_PULSE: assert property (o_pready |=> !o_pready)
    else $error("ready held past one cycle");
  AST_ERR_UNMAPPED: assert property (o_pslverr |-> o_pready && i_paddr > ADDR_RPHASE)
    else $error("error response on a mapped address");
  AST_START_CLEARS: assert property (start |-> ##[1:2] !o_done)
    else $error("done survives a new start");
  AST_TAVG_STEP: assert property (o_tavg_valid && o_tavg_idx != NBIN - 1 |=>
    o_tavg_valid && o_tavg_idx == $past(o_tavg_idx) + 8'h01)
    else $error("averaged record stream skips a sample");
  AST_TAVG_FIRST: assert property ($rose(o_tavg_valid) |-> o_tavg_idx == 8'h00)
    else $error("averaged record does not open at sample zero");
  AST_REQ_AFTER: assert property (o_tavg_valid && o_tavg_idx == NBIN - 1 |->
    ##[1:8] o_fft_req)
    else $error("no transform request after the averaged record");
  AST_REQ_SINGLE: assert property (o_fft_req |=> !o_fft_req [*8])
    else $error("transform requested more than once");
  AST_REQ_DONE: assert property (o_fft_req |-> ##[0:2] o_done)
    else $error("done missing after the transform request");
  AST_STREAM_NOT_DONE: assert property (o_tavg_valid |-> !o_done)
    else $error("done raised while the record still streams");
  // Main scenarios reached
  cover property (o_fft_req);
  cover property ($rose(o_done));
  cover property (o_pslverr);
endmodule : spavg_engine_chk

bind spavg_engine spavg_engine_chk #(.NBIN(NBIN)) u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_fft_req(o_fft_req), .o_tavg_idx(o_tavg_idx),
  .o_tavg_valid(o_tavg_valid), .o_done(o_done)
);

// File: bench/spavg_far_end.sv
module spavg_far_end (
  input wire logic i_clk,
  output logic o_fft_valid,
  output logic [spavg_pkg::BIN_W-1:0] o_fft_bin,
  output logic signed [spavg_pkg::DATA_W-1:0] o_fft_re,
  output logic signed [spavg_pkg::DATA_W-1:0] o_fft_im,
  output logic signed [spavg_pkg::PH_W-1:0] o_fft_phase,
  output logic o_smp_valid,
  output logic [spavg_pkg::BIN_W-1:0] o_smp_idx,
  output logic signed [spavg_pkg::DATA_W-1:0] o_smp_a,
  output logic signed [spavg_pkg::DATA_W-1:0] o_smp_b,
  output logic o_ext_trig
);
  timeunit 1ns;
  timeprecision 1ns;
  import spavg_pkg::*;
  integer seed = 32'h9798;
  // Quiet lines until the first burst
  initial begin
    {o_fft_valid, o_fft_bin, o_fft_re, o_fft_im, o_fft_phase} = '0;
    {o_smp_valid, o_smp_idx, o_smp_a, o_smp_b, o_ext_trig} = '0;
  end
  // One transform, a bin a cycle; bin value tells bins apart
  task automatic send_xfm(input logic [7:0] t);
    for (int b = 0; b < NBINS; b++) begin
      @(posedge i_clk);
      o_fft_valid <= 1'b1;
      o_fft_bin <= BIN_W'(b);
      o_fft_re <= DATA_W'(b);
      o_fft_im <= DATA_W'(t);
      o_fft_phase <= PH_W'(4 * t);
    end
    @(posedge i_clk);
    o_fft_valid <= 1'b0;
    // Inverted so a stale value is never taken for data
    {o_fft_re, o_fft_im, o_fft_phase} <= ~{o_fft_re, o_fft_im, o_fft_phase};
  endtask : send_xfm
  // Trigger edge, then a record whose sample 0 follows it
  task automatic send_rec(input logic [7:0] r);
    @(posedge i_clk);
    o_ext_trig <= 1'b1;
    repeat (2) @(posedge i_clk);
    o_ext_trig <= 1'b0;
    for (int i = 0; i < NBINS; i++) begin
      @(posedge i_clk);
      o_smp_valid <= 1'b1;
      o_smp_idx <= BIN_W'(i);
      o_smp_b <= DATA_W'(i + 4 * r);
      o_smp_a <= DATA_W'($random(seed)); // Unselected channel carries noise
    end
    @(posedge i_clk);
    o_smp_valid <= 1'b0;
    {o_smp_a, o_smp_b} <= ~{o_smp_a, o_smp_b};
  endtask : send_rec
endmodule : spavg_far_end

// File: bench/spavg_engine_bench.sv
module spavg_engine_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import spavg_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, fv, sv, trg, trig, req, tv, done;
  logic [BIN_W-1:0] fbin, sidx, tidx;
  logic signed [DATA_W-1:0] fre, fim, fph, sa, sb, tdat;
  int num_errors = 0;
  int checked = 0;
  int nreq = 0;
  int ntrig = 0;
  logic [63:0] rq[$];
  logic [15:0] tq[$];
  always #10 i_clk = ~i_clk;
  spavg_engine dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_fft_valid(fv), .i_fft_bin(fbin), .i_fft_re(fre),
    .i_fft_im(fim), .i_fft_phase(fph), .i_smp_valid(sv), .i_smp_idx(sidx),
    .i_smp_a(sa), .i_smp_b(sb), .i_ext_trig(trg), .o_trig(trig), .o_fft_req(req),
    .o_tavg_idx(tidx), .o_tavg_data(tdat), .o_tavg_valid(tv), .o_done(done)
  );
  spavg_far_end u_far (
    .i_clk(i_clk), .o_fft_valid(fv), .o_fft_bin(fbin), .o_fft_re(fre), .o_fft_im(fim),
    .o_fft_phase(fph), .o_smp_valid(sv), .o_smp_idx(sidx), .o_smp_a(sa), .o_smp_b(sb),
    .o_ext_trig(trg)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  // Oldest note is paired with each result as it shows
  always @(posedge i_clk) begin
    if (psel && pen && pready && !pwr && rq.size() > 0) begin
      check(prdata & rq[0][63:32], rq[0][31:0]);
      void'(rq.pop_front());
    end
    if (tv) begin
      check({16'h0, tdat}, tq.size() > 0 ? {16'h0, tq.pop_front()} : 32'hFFFFFFFF);
    end
    nreq += int'(req);
    ntrig += int'(trig);
  end
  // Holds the request until ready is sampled; no wait count assumed
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      final_report();
    end
    check({31'h0, pslverr}, {31'h0, a > ADDR_RPHASE});
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    rq.push_back({m, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic wait_done;
    for (int n = 0; n < 3000 && done !== 1'b1; n++) @(posedge i_clk);
    if (done !== 1'b1) begin
      num_errors++;
      final_report();
    end
  endtask : wait_done
  function automatic int isqrt(input int v);
    int r;
    r = 0;
    while ((r + 1) * (r + 1) <= v) r++;
    return r;
  endfunction : isqrt
  // Transforms t0.. with re = bin, im = t, phase = 4t; display idle time covered
  task automatic power(input int t0, input int n);
    int bl[3] = '{1, 7, 200};
    int k;
    int e;
    k = t0 + n;
    for (int t = t0; t < k; t++) begin
      u_far.send_xfm(8'(t));
      repeat (300) @(posedge i_clk);
    end
    wait_done();
    rd(ADDR_STAT, 32'h1FF00, 32'(k << 8));
    foreach (bl[i]) begin
      e = isqrt(bl[i] * bl[i] + ((k - 1) * k * (2 * k - 1) / 6) / k);
      apb(1'b1, ADDR_RADDR, 32'(bl[i]));
      rd(ADDR_RDATA, 32'hFFFFFFFF, 32'(e));
      rd(ADDR_RPHASE, 32'hFFFF, 32'(2 * (k - 1)));
    end
  endtask : power
  initial begin
    int kl[3] = '{1, 9, 8};
    int ke[3] = '{2, 2, 8};
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(ADDR_CTRL, 32'h1FFE, 32'h1220);
    rd(ADDR_STAT, 32'h1FF07, 32'h0);
    rd(32'h18, 32'h0, 32'h0);
    $display("test reset_and_map done");
    apb(1'b1, ADDR_CTRL, 32'h1021); // Power, K 4, display off
    repeat (260) @(posedge i_clk);
    power(0, 4);
    apb(1'b1, ADDR_CTRL, 32'h1230); // K 8 with no start
    power(4, 4);
    $display("test power_and_resume done");
    apb(1'b1, ADDR_CTRL, 32'h1629); // Time, external trigger, B only
    repeat (260) @(posedge i_clk);
    for (int i = 0; i < NBINS; i++) tq.push_back(16'(i + 6));
    nreq = 0;
    ntrig = 0;
    for (int r = 0; r < 4; r++) u_far.send_rec(8'(r));
    wait_done();
    repeat (2) @(posedge i_clk);
    check(32'(nreq), 32'h1);
    check(32'(ntrig), 32'h4);
    check(32'(tq.size()), 32'h0);
    $display("test time_average done");
    apb(1'b1, ADDR_CTRL, 32'h3624); // Exponential asked in time mode
    rd(ADDR_STAT, 32'h4, 32'h4);
    rd(ADDR_CTRL, 32'hC, 32'h8);
    apb(1'b1, ADDR_STAT, 32'h4);
    rd(ADDR_STAT, 32'h4, 32'h0);
    $display("test exp_refused done");
    apb(1'b1, ADDR_CTRL, 32'h102D); // Peak, K 4, start
    repeat (260) @(posedge i_clk);
    for (int t = 0; t < 4; t++) u_far.send_xfm(8'(t));
    wait_done();
    apb(1'b1, ADDR_RADDR, 32'h7);
    rd(ADDR_RDATA, 32'hFFFFFFFF, 32'h3A);
    $display("test peak_hold done");
    foreach (kl[i]) begin
      apb(1'b1, ADDR_CTRL, 32'h1200 | 32'(kl[i] << 4));
      rd(ADDR_CTRL, 32'hF0, 32'(ke[i] << 4));
    end
    $display("test k_bounds done");
    final_report();
  end
endmodule : spavg_engine_bench
